// ===== event_flag_reg.sv
// One sticky event flag byte cleared by an AND-masked write.
// Assumes set pulses and the write strobe are synchronous to clk.
`timescale 1ns/1ps
module event_flag_reg
   import pwr_evt_pkg::*;
#(
   parameter logic [7:0] MASK = 8'hFF
)
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Event and write side
   input  wire logic [7:0] set_evt,
   input  wire logic       wr_en,
   input  wire logic [7:0] wr_data,
   // Flags
   output logic [7:0]      flags
);

   logic [7:0] flags_r;
   logic [7:0] flags_nxt;

   always_comb
   begin
      flags_nxt = flags_r;
      if (wr_en)
         flags_nxt = flags_r & wr_data;
      // Set beats a clear in the same cycle so no event is lost
      flags_nxt = (flags_nxt | set_evt) & MASK;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         flags_r <= EVT_RESET;
      else
         flags_r <= flags_nxt;
   end

   assign flags = flags_r;

endmodule // event_flag_reg

// ===== pwr_evt_pkg.sv
// Package for the power status and event flag register bank.
// Assumes APB with 32-bit data; each 8-bit register sits in the low byte of one word.
package pwr_evt_pkg;

   // Register indices; the byte address is four times the index
   localparam logic [7:0] IDX_ADAPTER_STATUS   = 8'hA0;
   localparam logic [7:0] IDX_BATTERY1_STATUS  = 8'hA1;
   localparam logic [7:0] IDX_BATTERY2_STATUS  = 8'hA2;
   localparam logic [7:0] IDX_RESERVED_A3      = 8'hA3;
   localparam logic [7:0] IDX_BATTERY1_CAP     = 8'hA4;
   localparam logic [7:0] IDX_BATTERY2_CAP     = 8'hA5;
   localparam logic [7:0] IDX_RESERVED_A6      = 8'hA6;
   localparam logic [7:0] IDX_ALERT_SRC_ADDR   = 8'hA7;
   localparam logic [7:0] IDX_GPIO_A_EVT       = 8'hA8;
   localparam logic [7:0] IDX_GPIO_B_EVT       = 8'hA9;
   localparam logic [7:0] IDX_GPIO_C_EVT       = 8'hAA;
   localparam logic [7:0] IDX_RUN_EVT          = 8'hAB;
   localparam logic [7:0] IDX_WAKE_EVT         = 8'hAC;
   localparam logic [7:0] IDX_RUN_EVT_2        = 8'hAD;
   localparam logic [7:0] IDX_WAKE_EVT_2       = 8'hAE;
   localparam logic [7:0] IDX_THERMAL_EVT      = 8'hAF;
   localparam int         NUM_EVT_REGS         = 8;

   // Reset values
   localparam logic [7:0]  STATUS_RESET        = 8'h00;
   localparam logic [7:0]  EVT_RESET           = 8'h00;
   localparam logic [7:0]  ALERT_ADDR_RESET    = 8'h00;
   localparam logic [31:0] RDATA_ZERO          = 32'h0000_0000;

   // Writable bits of the event registers; the rest read as zero
   localparam logic [7:0]  GPIO_A_MASK         = 8'hFF;
   localparam logic [7:0]  GPIO_B_MASK         = 8'h7F;
   localparam logic [7:0]  GPIO_C_MASK         = 8'h03;
   localparam logic [7:0]  FULL_MASK           = 8'hFF;
   localparam logic [7:0]  THERMAL_MASK        = 8'h0F;

   // Run event byte layout
   localparam int RUN_SECOND_TRIP_BIT = 7;
   localparam int RUN_SMBUS_BIT       = 6;
   localparam int RUN_ALERT_BIT       = 5;
   localparam int RUN_GPIO_BIT        = 4;
   localparam int RUN_BAT2_BIT        = 1;
   localparam int RUN_BAT1_BIT        = 0;

   // Thermal event byte layout
   localparam int TH_EVENT_BIT        = 0;
   localparam int TH_HIGH_BIT         = 1;
   localparam int TH_LOW_BIT          = 2;
   localparam int TH_POLL_ERR_BIT     = 3;

   // Capacity encoding
   localparam logic [7:0] CAP_FULL_PERCENT   = 8'h64;
   localparam logic [7:0] CAP_UNKNOWN        = 8'h7F;
   localparam logic [7:0] CAP_NOT_INSTALLED  = 8'h80;

   // Alert arbitration
   localparam int         NUM_ALERT_SRC      = 4;
   localparam logic [7:0] ALERT_ADDR_EMPTY   = 8'h00;

   // Polling retries before the error flag is raised
   localparam logic [2:0] POLL_RETRY_LIMIT   = 3'h3;
   localparam logic [2:0] POLL_RETRY_ZERO    = 3'h0;

endpackage

// ===== pwr_evt_regs.sv
// Power status and event flag register bank with an APB slave port.
// Assumes event inputs are one-cycle pulses and status inputs are levels, all on pclk.
// Function
// - Read-only status bytes return a written value until a refresh or a status change.
// - The adapter status byte shows a 1 while an external adapter is attached.
// - Each battery status byte flags trip point, empty and low with a 1 each.
// - Each battery status byte also flags warning, error, discharging, charging and presence.
// - Capacity reads 0x00-0x64 for percent, 0x7F when unknown and 0x80 when no battery.
// - The alert-response function runs only while the alert address register is zero.
// - Of simultaneous alerting devices the lowest address is captured.
// - The host clears the alert address after reading it, then the next pending one loads.
// - A write to an event byte leaves old value AND written data.
// - The run event byte flags second trip, SMBus, alert, GPIO and per-battery events.
// - The thermal byte flags thermal events and crossing of the high and low alarm points.
// - An error flag is set when polling still fails after all retries.
// - Preserved status and capacity bytes ignore hardware updates during S4 or S5 sleep; writes still land.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
module pwr_evt_regs
   import pwr_evt_pkg::*;
(
   // APB slave
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [11:0]               paddr,
   input  wire logic [31:0]               pwdata,
   output logic [31:0]                    prdata,
   output logic                           pready,
   output logic                           pslverr,
   // Status levels
   input  wire logic                      adapter_present,
   input  wire logic [7:0]                bat1_state,
   input  wire logic [7:0]                bat2_state,
   input  wire logic [6:0]                bat1_percent,
   input  wire logic                      bat1_unknown,
   input  wire logic                      bat1_installed,
   input  wire logic [6:0]                bat2_percent,
   input  wire logic                      bat2_unknown,
   input  wire logic                      bat2_installed,
   input  wire logic                      status_refresh,
   input  wire logic                      deep_sleep,
   // SMBus alert sources
   input  wire logic [NUM_ALERT_SRC-1:0]  alert_src_req,
   input  wire logic [NUM_ALERT_SRC*7-1:0] alert_src_addr,
   output logic                           alert_respond,
   // Event pulses
   input  wire logic [7:0]                gpio_a_evt,
   input  wire logic [6:0]                gpio_b_evt,
   input  wire logic [1:0]                gpio_c_evt,
   input  wire logic                      second_trip_evt,
   input  wire logic                      smbus_evt,
   input  wire logic                      gpio_evt,
   input  wire logic                      bat1_evt,
   input  wire logic                      bat2_evt,
   input  wire logic [7:0]                wake_evt,
   input  wire logic [7:0]                run2_evt,
   input  wire logic [7:0]                wake2_evt,
   input  wire logic                      thermal_evt,
   input  wire logic                      thermal_high_evt,
   input  wire logic                      thermal_low_evt,
   input  wire logic                      poll_fail,
   input  wire logic                      poll_ok
);

   ////////////////////////////////////////////////////////////////////////////
   // APB decode
   ////////////////////////////////////////////////////////////////////////////

   logic [31:0] prdata_r;
   logic [31:0] prdata_nxt;
   logic        pready_r;
   logic        pready_nxt;
   logic        pslverr_r;
   logic        pslverr_nxt;
   logic [7:0]  reg_idx;
   logic        addr_hit;
   logic        wr_commit;
   logic [7:0]  wr_byte;
   logic [7:0]  rd_byte;

   assign reg_idx   = paddr[9:2];
   assign addr_hit  = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0)
                      && (reg_idx >= IDX_ADAPTER_STATUS) && (reg_idx <= IDX_THERMAL_EVT);
   // Writes land only at the edge where the slave shows ready
   assign wr_commit = psel && penable && pready_r && pwrite && addr_hit;
   assign wr_byte   = pwdata[7:0];

   ////////////////////////////////////////////////////////////////////////////
   // Status bytes
   ////////////////////////////////////////////////////////////////////////////

   logic [7:0] adp_hw;
   logic [7:0] cap1_hw;
   logic [7:0] cap2_hw;
   logic [7:0] adapter_status;
   logic [7:0] battery1_status;
   logic [7:0] battery2_status;
   logic [7:0] battery1_capacity;
   logic [7:0] battery2_capacity;

   function automatic logic [7:0] encode_cap(input logic [6:0] pct,
                                             input logic       unknown,
                                             input logic       installed);
      logic [7:0] code;
      code = {1'b0, pct};
      if (!installed)
         code = CAP_NOT_INSTALLED;
      else if (unknown)
         code = CAP_UNKNOWN;
      else if (code > CAP_FULL_PERCENT)
         code = CAP_FULL_PERCENT;
      return code;
   endfunction

   // Bit 0 is the adapter presence flag, the rest reserved
   assign adp_hw  = {7'h00, adapter_present};
   assign cap1_hw = encode_cap(bat1_percent, bat1_unknown, bat1_installed);
   assign cap2_hw = encode_cap(bat2_percent, bat2_unknown, bat2_installed);

   // Battery byte: trip, empty, low, warning, error, discharging, charging, present
   status_shadow_reg u_adp
   (
      .clk     (pclk),
      .rst_n   (presetn),
      .hw_val  (adp_hw),
      .refresh (status_refresh),
      .hold    (deep_sleep),
      .wr_en   (wr_commit && (reg_idx == IDX_ADAPTER_STATUS)),
      .wr_data (wr_byte),
      .val     (adapter_status)
   );

   status_shadow_reg u_bat1
   (
      .clk     (pclk),
      .rst_n   (presetn),
      .hw_val  (bat1_state),
      .refresh (status_refresh),
      .hold    (deep_sleep),
      .wr_en   (wr_commit && (reg_idx == IDX_BATTERY1_STATUS)),
      .wr_data (wr_byte),
      .val     (battery1_status)
   );

   status_shadow_reg u_bat2
   (
      .clk     (pclk),
      .rst_n   (presetn),
      .hw_val  (bat2_state),
      .refresh (status_refresh),
      .hold    (deep_sleep),
      .wr_en   (wr_commit && (reg_idx == IDX_BATTERY2_STATUS)),
      .wr_data (wr_byte),
      .val     (battery2_status)
   );

   status_shadow_reg u_cap1
   (
      .clk     (pclk),
      .rst_n   (presetn),
      .hw_val  (cap1_hw),
      .refresh (status_refresh),
      .hold    (deep_sleep),
      .wr_en   (wr_commit && (reg_idx == IDX_BATTERY1_CAP)),
      .wr_data (wr_byte),
      .val     (battery1_capacity)
   );

   status_shadow_reg u_cap2
   (
      .clk     (pclk),
      .rst_n   (presetn),
      .hw_val  (cap2_hw),
      .refresh (status_refresh),
      .hold    (deep_sleep),
      .wr_en   (wr_commit && (reg_idx == IDX_BATTERY2_CAP)),
      .wr_data (wr_byte),
      .val     (battery2_capacity)
   );

   ////////////////////////////////////////////////////////////////////////////
   // SMBus alert source address
   ////////////////////////////////////////////////////////////////////////////

   logic [7:0]               alert_addr_r;
   logic [7:0]               alert_addr_nxt;
   logic [NUM_ALERT_SRC-1:0] alert_pend_r;
   logic [NUM_ALERT_SRC-1:0] alert_pend_nxt;
   logic                     alert_respond_r;
   logic                     alert_respond_nxt;
   logic                     alert_capture;
   logic [6:0]               alert_min_addr;
   logic [NUM_ALERT_SRC-1:0] alert_min_sel;

   // Lowest address among pending sources, as SMBus arbitration would pick
   always_comb
   begin
      alert_min_addr = 7'h7F;
      alert_min_sel  = '0;
      for (int i = 0; i < NUM_ALERT_SRC; i++)
      begin
         if (alert_pend_r[i] && (alert_src_addr[i*7 +: 7] <= alert_min_addr))
         begin
            alert_min_addr = alert_src_addr[i*7 +: 7];
            alert_min_sel  = '0;
            alert_min_sel[i] = 1'b1;
         end
      end
   end

   // Response runs only on an empty register, so a host write of zero releases the next
   assign alert_capture = (alert_addr_r == ALERT_ADDR_EMPTY) && (alert_pend_r != '0);

   always_comb
   begin
      alert_addr_nxt    = alert_addr_r;
      alert_pend_nxt    = alert_pend_r;
      alert_respond_nxt = 1'b0;
      if (wr_commit && (reg_idx == IDX_ALERT_SRC_ADDR))
         alert_addr_nxt = wr_byte;
      if (alert_capture)
      begin
         alert_addr_nxt    = {alert_min_addr, 1'b0};
         alert_pend_nxt    = alert_pend_r & ~alert_min_sel;
         alert_respond_nxt = 1'b1;
      end
      alert_pend_nxt = alert_pend_nxt | alert_src_req;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         alert_addr_r    <= ALERT_ADDR_RESET;
         alert_pend_r    <= '0;
         alert_respond_r <= 1'b0;
      end
      else
      begin
         alert_addr_r    <= alert_addr_nxt;
         alert_pend_r    <= alert_pend_nxt;
         alert_respond_r <= alert_respond_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Polling retry counter
   ////////////////////////////////////////////////////////////////////////////

   logic [2:0] retry_cnt_r;
   logic [2:0] retry_cnt_nxt;
   logic       poll_err_evt;

   // One pulse when the failure count reaches the limit; more failures stay silent
   assign poll_err_evt = poll_fail && (retry_cnt_r == POLL_RETRY_LIMIT - 3'h1);

   always_comb
   begin
      retry_cnt_nxt = retry_cnt_r;
      if (poll_ok)
         retry_cnt_nxt = POLL_RETRY_ZERO;
      else if (poll_fail && (retry_cnt_r != POLL_RETRY_LIMIT))
         retry_cnt_nxt = retry_cnt_r + 3'h1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         retry_cnt_r <= POLL_RETRY_ZERO;
      else
         retry_cnt_r <= retry_cnt_nxt;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Event flag bytes
   ////////////////////////////////////////////////////////////////////////////

   logic [7:0] evt_set  [NUM_EVT_REGS];
   logic [7:0] evt_val  [NUM_EVT_REGS];
   logic [7:0] run_set;
   logic [7:0] th_set;

   always_comb
   begin
      run_set = 8'h00;
      run_set[RUN_SECOND_TRIP_BIT] = second_trip_evt;
      run_set[RUN_SMBUS_BIT]       = smbus_evt;
      run_set[RUN_ALERT_BIT]       = alert_capture;
      run_set[RUN_GPIO_BIT]        = gpio_evt;
      run_set[RUN_BAT2_BIT]        = bat2_evt;
      run_set[RUN_BAT1_BIT]        = bat1_evt;
      th_set = 8'h00;
      th_set[TH_EVENT_BIT]    = thermal_evt;
      th_set[TH_HIGH_BIT]     = thermal_high_evt;
      th_set[TH_LOW_BIT]      = thermal_low_evt;
      th_set[TH_POLL_ERR_BIT] = poll_err_evt;
   end

   assign evt_set[0] = gpio_a_evt;
   assign evt_set[1] = {1'b0, gpio_b_evt};
   assign evt_set[2] = {6'h00, gpio_c_evt};
   assign evt_set[3] = run_set;
   assign evt_set[4] = wake_evt;
   assign evt_set[5] = run2_evt;
   assign evt_set[6] = wake2_evt;
   assign evt_set[7] = th_set;

   localparam logic [7:0] EVT_MASKS [NUM_EVT_REGS] = '{GPIO_A_MASK, GPIO_B_MASK, GPIO_C_MASK,
      FULL_MASK, FULL_MASK, FULL_MASK, FULL_MASK, THERMAL_MASK};

   for (genvar g = 0; g < NUM_EVT_REGS; g++)
   begin : g_evt
      event_flag_reg #(.MASK(EVT_MASKS[g])) u_evt
      (
         .clk     (pclk),
         .rst_n   (presetn),
         .set_evt (evt_set[g]),
         .wr_en   (wr_commit && (reg_idx == IDX_GPIO_A_EVT + 8'(g))),
         .wr_data (wr_byte),
         .flags   (evt_val[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read mux and APB answer
   ////////////////////////////////////////////////////////////////////////////

   always_comb
   begin
      rd_byte = 8'h00;
      if (reg_idx == IDX_ADAPTER_STATUS)
         rd_byte = adapter_status;
      else if (reg_idx == IDX_BATTERY1_STATUS)
         rd_byte = battery1_status;
      else if (reg_idx == IDX_BATTERY2_STATUS)
         rd_byte = battery2_status;
      else if (reg_idx == IDX_BATTERY1_CAP)
         rd_byte = battery1_capacity;
      else if (reg_idx == IDX_BATTERY2_CAP)
         rd_byte = battery2_capacity;
      else if (reg_idx == IDX_ALERT_SRC_ADDR)
         rd_byte = alert_addr_r;
      else if (reg_idx >= IDX_GPIO_A_EVT && reg_idx <= IDX_THERMAL_EVT)
         rd_byte = evt_val[3'(reg_idx - IDX_GPIO_A_EVT)];
   end

   // One wait state: ready rises in the second access cycle, for one cycle only
   always_comb
   begin
      pready_nxt  = 1'b0;
      pslverr_nxt = 1'b0;
      prdata_nxt  = RDATA_ZERO;
      if (psel && penable && !pready_r)
      begin
         pready_nxt  = 1'b1;
         pslverr_nxt = !addr_hit;
         if (!pwrite && addr_hit)
            prdata_nxt = {24'h000000, rd_byte};
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_r  <= RDATA_ZERO;
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
      end
      else
      begin
         prdata_r  <= prdata_nxt;
         pready_r  <= pready_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   assign prdata        = prdata_r;
   assign pready        = pready_r;
   assign pslverr       = pslverr_r;
   assign alert_respond = alert_respond_r;

endmodule // pwr_evt_regs

// ===== pwr_evt_regs_monitor.sv
// Checker for the APB answer and alert pulse of the register bank.
// Assumes it is bound to pwr_evt_regs and sees only its ports.
`timescale 1ns/1ps
module pwr_evt_regs_monitor
   import pwr_evt_pkg::*;
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   // Alert
   input  wire logic        alert_respond
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   logic mapped;
   // Word indices A0..AF land on byte addresses 0x280..0x2BC
   assign mapped = (paddr[1:0] == 2'h0) && (paddr[11:6] == 6'h0A);

   sequence acc_s;
      psel && penable && !pready;
   endsequence
   sequence first_acc_s;
      psel && $rose(penable);
   endsequence

   ans_time_a:  assert property (first_acc_s |=> pready) else $error("late answer");
   ready_one_a: assert property (pready |=> !pready) else $error("pready too long");
   rdata_idle_a: assert property (!pready |-> prdata == RDATA_ZERO) else $error("stray rdata");
   err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
   err_unmap_a: assert property (acc_s ##0 !mapped |=> pslverr) else $error("unmapped ok");
   ok_mapped_a: assert property (acc_s ##0 mapped |=> !pslverr) else $error("mapped error");
   upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper bits set");
   rsvd_zero_a: assert property (acc_s ##0 (!pwrite && (paddr == 12'h28C || paddr == 12'h298))
      |=> prdata == RDATA_ZERO) else $error("reserved nonzero");
   wr_nodata_a: assert property (acc_s ##0 pwrite |=> prdata == RDATA_ZERO) else $error("wr data");
   resp_pulse_a: assert property (alert_respond |=> !alert_respond) else $error("long resp");
endmodule // pwr_evt_regs_monitor

// ===== status_shadow_reg.sv
// Read-only status byte that keeps a software write until hardware refreshes it.
// Assumes hw_val and refresh are synchronous to clk.
`timescale 1ns/1ps
module status_shadow_reg
   import pwr_evt_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Hardware side
   input  wire logic [7:0] hw_val,
   input  wire logic       refresh,
   input  wire logic       hold,
   // Write side
   input  wire logic       wr_en,
   input  wire logic [7:0] wr_data,
   // Value seen by software
   output logic [7:0]      val
);

   logic [7:0] val_r;
   logic [7:0] val_nxt;
   logic [7:0] last_hw_r;
   logic [7:0] last_hw_nxt;

   always_comb
   begin
      val_nxt     = val_r;
      last_hw_nxt = hw_val;
      if (wr_en)
         val_nxt = wr_data;
      // Hardware update wins over a write in the same cycle; hold blocks hardware updates but not writes
      if (!hold && (refresh || (hw_val != last_hw_r)))
         val_nxt = hw_val;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         val_r     <= STATUS_RESET;
         last_hw_r <= STATUS_RESET;
      end
      else
      begin
         val_r     <= val_nxt;
         last_hw_r <= last_hw_nxt;
      end
   end

   assign val = val_r;

endmodule // status_shadow_reg

// ===== test_power_status_event_registers.sv
// Self-checking bench for the power status and event flag register bank.
// Assumes pwr_evt_regs with an APB slave answering in two access cycles.
`timescale 1ns/1ps
module test_power_status_event_registers
   import pwr_evt_pkg::*;
();
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready, pslverr, alert_respond, err_v;
   logic        adapter_present = 1'b0, bat1_unknown = 1'b0, bat1_installed = 1'b1;
   logic        bat2_unknown = 1'b1, bat2_installed = 1'b1, status_refresh = 1'b0;
   logic        deep_sleep = 1'b0, second_trip_evt = 1'b0, smbus_evt = 1'b0, gpio_evt = 1'b0;
   logic        bat1_evt = 1'b0, bat2_evt = 1'b0, thermal_evt = 1'b0, thermal_high_evt = 1'b0;
   logic        thermal_low_evt = 1'b0, poll_fail = 1'b0, poll_ok = 1'b0;
   logic [7:0]  bat1_state = 8'h00, bat2_state = 8'h00, rd_v;
   logic [7:0]  gpio_a_evt = 8'h00, wake_evt = 8'h00, run2_evt = 8'h00, wake2_evt = 8'h00;
   logic [6:0]  bat1_percent = 7'h00, bat2_percent = 7'h00, gpio_b_evt = 7'h00;
   logic [1:0]  gpio_c_evt = 2'h0;
   logic [3:0]  alert_src_req = 4'h0;
   logic [27:0] alert_src_addr = {7'h20, 7'h50, 7'h12, 7'h30};
   int          fail_count = 0, n_checks = 0, resp_count = 0;
   typedef struct { logic [6:0] pct; logic unk; logic inst; logic [7:0] exp; } cap_t;
   typedef struct { logic [7:0] idx; logic [7:0] exp; } ev_t;
   cap_t cap_rows[4] = '{'{7'h00, 1'b0, 1'b1, 8'h00}, '{7'h64, 1'b0, 1'b1, 8'h64},
                         '{7'h32, 1'b1, 1'b1, 8'h7F}, '{7'h32, 1'b0, 1'b0, 8'h80}};
   ev_t  ev_rows[8]  = '{'{8'hA8, 8'hFF}, '{8'hA9, 8'h7F}, '{8'hAA, 8'h03}, '{8'hAB, 8'hD3},
                         '{8'hAC, 8'hFF}, '{8'hAD, 8'hFF}, '{8'hAE, 8'hFF}, '{8'hAF, 8'h07}};

   always #5 pclk = ~pclk;
   always @(posedge pclk) if (alert_respond === 1'b1) resp_count++;

   pwr_evt_regs DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .adapter_present, .bat1_state, .bat2_state, .bat1_percent,
      .bat1_unknown, .bat1_installed, .bat2_percent, .bat2_unknown, .bat2_installed,
      .status_refresh, .deep_sleep, .alert_src_req, .alert_src_addr, .alert_respond,
      .gpio_a_evt, .gpio_b_evt, .gpio_c_evt, .second_trip_evt, .smbus_evt, .gpio_evt,
      .bat1_evt, .bat2_evt, .wake_evt, .run2_evt, .wake2_evt, .thermal_evt,
      .thermal_high_evt, .thermal_low_evt, .poll_fail, .poll_ok);

   ////////////////////////////////////////////////////////////////////////////////
   task automatic close_out;
      if (fail_count == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("Error at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   // One idle edge first, so a strobe is never driven twice in one time step
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                      output logic [7:0] r, output logic e);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      r = prdata[7:0];
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20)
      begin
         fail_count++;
         close_out();
      end
   endtask
   task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
      apb(1'b0, {2'b00, idx, 2'b00}, 8'h00, rd_v, err_v);
      chk(rd_v, exp);
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      apb(1'b1, {2'b00, idx, 2'b00}, d, rd_v, err_v);
   endtask
   task automatic refresh;
      @(posedge pclk) status_refresh <= 1'b1;
      @(posedge pclk) status_refresh <= 1'b0;
   endtask
   task automatic poll(input logic f);
      @(posedge pclk);
      poll_fail <= f;
      poll_ok <= !f;
      @(posedge pclk);
      poll_fail <= 1'b0;
      poll_ok <= 1'b0;
   endtask
   task automatic all_events(input logic v);
      @(posedge pclk);
      {gpio_a_evt, gpio_b_evt, gpio_c_evt, wake_evt, run2_evt, wake2_evt} <= {41{v}};
      {second_trip_evt, smbus_evt, gpio_evt, bat1_evt, bat2_evt} <= {5{v}};
      {thermal_evt, thermal_high_evt, thermal_low_evt} <= {3{v}};
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      adapter_present <= 1'b1;
      bat1_state <= 8'hA5;
      bat2_state <= 8'h5A;
      foreach (cap_rows[i])
      begin
         @(posedge pclk);
         bat1_percent <= cap_rows[i].pct;
         bat1_unknown <= cap_rows[i].unk;
         bat1_installed <= cap_rows[i].inst;
         refresh();
         rd(IDX_BATTERY1_CAP, cap_rows[i].exp);
      end
      rd(IDX_ADAPTER_STATUS, 8'h01);
      rd(IDX_BATTERY1_STATUS, 8'hA5);
      rd(IDX_BATTERY2_STATUS, 8'h5A);
      rd(IDX_BATTERY2_CAP, CAP_UNKNOWN);
      wr(IDX_BATTERY1_STATUS, 8'h3C);
      rd(IDX_BATTERY1_STATUS, 8'h3C);
      refresh();
      rd(IDX_BATTERY1_STATUS, 8'hA5);
      @(posedge pclk);
      deep_sleep <= 1'b1;
      bat1_state <= 8'h11;
      refresh();
      rd(IDX_BATTERY1_STATUS, 8'hA5);
      @(posedge pclk) deep_sleep <= 1'b0;
      refresh();
      rd(IDX_BATTERY1_STATUS, 8'h11);
      // Event bytes: set, partial AND clear, full clear
      all_events(1'b1);
      all_events(1'b0);
      foreach (ev_rows[i])
      begin
         rd(ev_rows[i].idx, ev_rows[i].exp);
         wr(ev_rows[i].idx, 8'h0F);
         rd(ev_rows[i].idx, ev_rows[i].exp & 8'h0F);
         wr(ev_rows[i].idx, 8'h00);
         rd(ev_rows[i].idx, 8'h00);
      end
      // A success in between restarts the retry count
      poll(1'b1);
      poll(1'b1);
      poll(1'b0);
      poll(1'b1);
      poll(1'b1);
      rd(IDX_THERMAL_EVT, 8'h00);
      poll(1'b1);
      rd(IDX_THERMAL_EVT, 8'h08);
      // Two alerts at once, then a blocked capture
      @(posedge pclk) alert_src_req <= 4'b0011;
      @(posedge pclk) alert_src_req <= 4'b0000;
      rd(IDX_ALERT_SRC_ADDR, 8'h24);
      wr(IDX_ALERT_SRC_ADDR, 8'h00);
      rd(IDX_ALERT_SRC_ADDR, 8'h60);
      wr(IDX_ALERT_SRC_ADDR, 8'h00);
      rd(IDX_ALERT_SRC_ADDR, 8'h00);
      wr(IDX_ALERT_SRC_ADDR, 8'h02);
      @(posedge pclk) alert_src_req <= 4'b0100;
      @(posedge pclk) alert_src_req <= 4'b0000;
      rd(IDX_ALERT_SRC_ADDR, 8'h02);
      wr(IDX_ALERT_SRC_ADDR, 8'h00);
      rd(IDX_ALERT_SRC_ADDR, 8'hA0);
      rd(IDX_RUN_EVT, 8'h20);
      chk(resp_count, 3);
      // Unmapped, misaligned and reserved places
      apb(1'b0, 12'h2C0, 8'h00, rd_v, err_v);
      chk(err_v, 1'b1);
      apb(1'b1, 12'h281, 8'hFF, rd_v, err_v);
      chk(err_v, 1'b1);
      wr(IDX_RESERVED_A3, 8'hFF);
      rd(IDX_RESERVED_A3, 8'h00);
      fork
         wr(IDX_GPIO_A_EVT, 8'h00);
         begin
            repeat (2) @(posedge pclk);
            all_events(1'b1);
            all_events(1'b0);
         end
      join
      rd(IDX_GPIO_A_EVT, 8'hFF);
      @(posedge pclk) presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rd(IDX_GPIO_A_EVT, EVT_RESET);
      rd(IDX_THERMAL_EVT, EVT_RESET);
      rd(IDX_ALERT_SRC_ADDR, ALERT_ADDR_RESET);
      close_out();
   end
endmodule // test_power_status_event_registers

bind pwr_evt_regs pwr_evt_regs_monitor mon (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .prdata, .pready, .pslverr, .alert_respond);
